// ### hw/psl_pkg.sv
// constants, register map and carrier types for the strap, indicator and isolate block
package psl_pkg;

   // management register addresses
   localparam logic [4:0] PSL_ADDR_BASIC_MODE   = 5'h00;
   localparam logic [4:0] PSL_ADDR_PHY_STATUS   = 5'h10;
   localparam logic [4:0] PSL_ADDR_LED_OVERRIDE = 5'h18;
   localparam logic [4:0] PSL_ADDR_PHY_CONFIG   = 5'h19;

   // basic_mode_control fields
   localparam int PSL_BMC_LOOPBACK_BIT = 14;
   localparam int PSL_BMC_ISOLATE_BIT  = 10;
   localparam logic [15:0] PSL_BMC_RESET = 16'h0000;

   // phy_status_report fields
   localparam int PSL_STS_LINK_BIT     = 0;
   localparam int PSL_STS_SPEED10_BIT  = 1;
   localparam int PSL_STS_DUPLEX_BIT   = 2;
   localparam int PSL_STS_LOOPBACK_BIT = 3;

   // phy_config_control fields
   localparam int PSL_CFG_ADDR_LSB = 0;
   localparam int PSL_CFG_ADDR_MSB = 4;
   localparam int PSL_CFG_MODE_LSB = 5;
   localparam int PSL_CFG_MODE_MSB = 6;
   localparam logic [15:0] PSL_CFG_RESET = 16'h0000;

   // led_override_control fields: values in [2:0], enables in [5:3]
   localparam int PSL_LED_VAL_LSB = 0;
   localparam int PSL_LED_EN_LSB  = 3;
   localparam logic [15:0] PSL_LED_RESET    = 16'h0000;
   localparam logic [15:0] PSL_LED_WR_MASK  = 16'h003f;

   // ten megabit link qualification
   localparam logic [2:0] PSL_NLP_NEEDED = 3'h7;

   // blink timing
   localparam int PSL_CLK_MHZ      = 200;
   localparam int PSL_BLINK_HALF_MS = 50;
   localparam int PSL_BLINK_CYCLES = PSL_BLINK_HALF_MS * 1000 * PSL_CLK_MHZ;

   typedef struct packed {
      logic        we;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } psl_mgmt_req_t;

   typedef struct packed {
      logic       dv;
      logic       er;
      logic       crs;
      logic [3:0] d;
   } psl_rx_t;

endpackage

// ### hw/psl_top.sv
// strap capture, isolate, indicator, duplex and loopback logic of the transceiver
`timescale 1ns/1ps
module psl_top
   import psl_pkg::*;
#(
   parameter int BLINK_CYCLES = PSL_BLINK_CYCLES
) (
   input  wire logic          core_clk,
   input  wire logic          rstn,
   input  wire logic [4:0]    mgmt_addr_strap,
   input  wire logic [2:0]    autoneg_strap,
   input  wire logic          mgmt_req_valid,
   input  wire psl_mgmt_req_t mgmt_req,
   output logic               mgmt_rvalid,
   output logic [15:0]        mgmt_rdata,
   input  wire logic          mii_tx_en,
   input  wire logic [3:0]    mii_txd,
   output psl_rx_t            mii_rx,
   output logic               mii_col,
   output logic               mii_out_oe,
   input  wire psl_rx_t       line_rx,
   input  wire logic          line_collision,
   output logic               line_tx_en,
   output logic [3:0]         line_txd,
   output logic               line_idle,
   input  wire logic          speed_100,
   input  wire logic          resolved_full,
   input  wire logic          parallel_detect,
   input  wire logic          signal_detect,
   input  wire logic          link_pulse,
   input  wire logic          valid_packet_10,
   input  wire logic          link_loss,
   output logic               link_indicator,
   output logic               speed_indicator,
   output logic               activity_collision_indicator
);

   logic [15:0] basic_mode_control;
   logic [15:0] phy_config_control;
   logic [15:0] led_override_control;
   logic        strap_done;
   logic [2:0]  led_polarity;
   logic [2:0]  nlp_count;
   logic        link_10;
   logic [31:0] blink_count;
   logic        blink_phase;

   wire         wr_hit      = mgmt_req_valid & mgmt_req.we;
   wire         wr_bmc      = wr_hit & (mgmt_req.addr == PSL_ADDR_BASIC_MODE);
   wire         wr_cfg      = wr_hit & (mgmt_req.addr == PSL_ADDR_PHY_CONFIG);
   wire         wr_led      = wr_hit & (mgmt_req.addr == PSL_ADDR_LED_OVERRIDE);
   wire         isolate     = basic_mode_control[PSL_BMC_ISOLATE_BIT];
   wire         loopback    = basic_mode_control[PSL_BMC_LOOPBACK_BIT];
   wire         full_duplex = resolved_full & ~parallel_detect;
   wire         link_up     = speed_100 ? signal_detect : link_10;
   wire [1:0]   ind_mode    = phy_config_control[PSL_CFG_MODE_MSB:PSL_CFG_MODE_LSB];
   wire         mode_one    = ind_mode[0];
   wire         mode_two    = (ind_mode == 2'b00);
   wire         tx_active   = mii_tx_en & ~isolate;
   wire         rx_active   = loopback ? tx_active : line_rx.crs;
   wire         activity    = tx_active | rx_active;
   wire         collision   = ~full_duplex & ~loopback & tx_active & line_collision;
   wire [15:0]  status_word = {12'h000, loopback, full_duplex, ~speed_100, link_up};

   // indicator logic before override and polarity
   wire         link_raw  = mode_one ? link_up : (link_up & ~(activity & blink_phase));
   wire         speed_raw = speed_100;
   wire         ac_raw    = mode_one ? activity :
                            (mode_two ? collision : full_duplex);
   wire [2:0]   ind_raw   = {ac_raw, speed_raw, link_raw};
   wire [2:0]   ovr_en    = led_override_control[PSL_LED_EN_LSB +: 3];
   wire [2:0]   ovr_val   = led_override_control[PSL_LED_VAL_LSB +: 3];
   wire [2:0]   ind_sel   = (ovr_en & ovr_val) | (~ovr_en & ind_raw);
   wire [2:0]   next_ind  = ind_sel ^ led_polarity;

   // read mux; unmapped addresses answer zero
   wire [15:0]  next_rdata =
      (mgmt_req.addr == PSL_ADDR_BASIC_MODE)   ? basic_mode_control :
      (mgmt_req.addr == PSL_ADDR_PHY_STATUS)   ? status_word :
      (mgmt_req.addr == PSL_ADDR_LED_OVERRIDE) ? led_override_control :
      (mgmt_req.addr == PSL_ADDR_PHY_CONFIG)   ? phy_config_control : 16'h0000;

   // received nibble stream towards the MAC
   psl_rx_t next_rx;
   always_comb begin
      next_rx = line_rx;
      if (loopback) begin
         next_rx.dv  = tx_active;
         next_rx.er  = 1'b0;
         next_rx.d   = mii_txd;
      end
      next_rx.crs = rx_active | (~full_duplex & tx_active);
   end

   // straps are sampled on the first edge after release, not under reset,
   // so the pins have settled and the flops take only constants at reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap_done   <= 1'b0;
         led_polarity <= 3'h0;
      end else if (!strap_done) begin
         strap_done   <= 1'b1;
         led_polarity <= autoneg_strap;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         basic_mode_control <= PSL_BMC_RESET;
      end else if (!strap_done) begin
         basic_mode_control[PSL_BMC_ISOLATE_BIT] <= (mgmt_addr_strap == 5'h00);
      end else if (wr_bmc) begin
         basic_mode_control <= mgmt_req.wdata;
      end
   end

   // address writes only land in the register; isolate takes the strap and basic_mode_control writes, never the written address
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phy_config_control <= PSL_CFG_RESET;
      end else if (!strap_done) begin
         phy_config_control[PSL_CFG_ADDR_MSB:PSL_CFG_ADDR_LSB] <= mgmt_addr_strap;
      end else if (wr_cfg) begin
         phy_config_control <= mgmt_req.wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         led_override_control <= PSL_LED_RESET;
      end else if (wr_led) begin
         led_override_control <= mgmt_req.wdata & PSL_LED_WR_MASK;
      end
   end

   // management answers are never gated by isolate
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mgmt_rvalid <= 1'b0;
         mgmt_rdata  <= 16'h0000;
      end else begin
         mgmt_rvalid <= mgmt_req_valid & ~mgmt_req.we;
         mgmt_rdata  <= (mgmt_req_valid & ~mgmt_req.we) ? next_rdata : 16'h0000;
      end
   end

   // ten megabit link qualification runs regardless of isolate
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         nlp_count <= 3'h0;
         link_10   <= 1'b0;
      end else if (link_loss) begin
         nlp_count <= 3'h0;
         link_10   <= 1'b0;
      end else begin
         if (link_pulse && nlp_count != PSL_NLP_NEEDED) begin
            nlp_count <= nlp_count + 3'h1;
         end
         if (valid_packet_10 || (link_pulse && nlp_count == PSL_NLP_NEEDED - 3'h1)) begin
            link_10 <= 1'b1;
         end
      end
   end

   // free running blink base; a slow rate costs one wide counter
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         blink_count <= 32'h0;
         blink_phase <= 1'b0;
      end else if (blink_count == 32'(BLINK_CYCLES - 1)) begin
         blink_count <= 32'h0;
         blink_phase <= ~blink_phase;
      end else begin
         blink_count <= blink_count + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mii_rx     <= '0;
         mii_col    <= 1'b0;
         mii_out_oe <= 1'b0;
         line_tx_en <= 1'b0;
         line_txd   <= 4'h0;
         line_idle  <= 1'b1;
      end else begin
         mii_rx     <= next_rx;
         mii_col    <= collision;
         mii_out_oe <= strap_done & ~isolate;
         line_tx_en <= tx_active & ~loopback;
         line_txd   <= (tx_active & ~loopback) ? mii_txd : 4'h0;
         line_idle  <= ~(tx_active & ~loopback);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         link_indicator               <= 1'b0;
         speed_indicator              <= 1'b0;
         activity_collision_indicator <= 1'b0;
      end else begin
         link_indicator               <= next_ind[0];
         speed_indicator              <= next_ind[1];
         activity_collision_indicator <= next_ind[2];
      end
   end

   // sampled rstn keeps the release edge itself out of the strap checks
   chk_strap_addr_capture: assert property (@(posedge core_clk) disable iff (!rstn)
      (rstn && !strap_done) |=> phy_config_control[4:0] == $past(mgmt_addr_strap))
      else $error("address strap not captured");

   chk_zero_strap_isolate: assert property (@(posedge core_clk) disable iff (!rstn)
      (rstn && !strap_done && mgmt_addr_strap == 5'h00) |=> isolate ##1 !mii_out_oe)
      else $error("zero strap did not isolate");

   chk_cfg_write_no_iso: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && wr_cfg && !wr_bmc) |=> isolate == $past(isolate))
      else $error("config write changed isolate");

   chk_isolate_floats: assert property (@(posedge core_clk) disable iff (!rstn)
      isolate |=> !mii_out_oe && !line_tx_en)
      else $error("isolate did not float outputs");

   chk_read_answered: assert property (@(posedge core_clk) disable iff (!rstn)
      (mgmt_req_valid && !mgmt_req.we) |=> mgmt_rvalid)
      else $error("management read not answered");

   chk_loop_no_line: assert property (@(posedge core_clk) disable iff (!rstn)
      loopback |=> !line_tx_en && line_idle)
      else $error("line driven during loopback");

   chk_loop_rx_data: assert property (@(posedge core_clk) disable iff (!rstn)
      (loopback && tx_active) |=> mii_rx.dv && mii_rx.d == $past(mii_txd))
      else $error("loopback data not returned");

   chk_full_no_col: assert property (@(posedge core_clk) disable iff (!rstn)
      full_duplex |=> !mii_col)
      else $error("collision in full duplex");

   chk_half_crs_tx: assert property (@(posedge core_clk) disable iff (!rstn)
      (!full_duplex && tx_active) |=> mii_rx.crs)
      else $error("carrier sense missing on transmit");

   chk_nlp_link: assert property (@(posedge core_clk) disable iff (!rstn)
      (!link_loss && link_pulse && nlp_count == 3'h6) |=> link_10)
      else $error("link not declared after seven pulses");

   chk_speed_led: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && !ovr_en[1]) |=> speed_indicator == ($past(speed_100) ^ led_polarity[1]))
      else $error("speed indicator wrong");

   chk_sts_loopback: assert property (@(posedge core_clk) disable iff (!rstn)
      (mgmt_req_valid && !mgmt_req.we && mgmt_req.addr == PSL_ADDR_PHY_STATUS)
      |=> mgmt_rdata[3] == $past(loopback))
      else $error("status loopback bit wrong");

   chk_bmc_write_iso: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && wr_bmc && mgmt_req.wdata[PSL_BMC_ISOLATE_BIT]) |=> isolate)
      else $error("isolate bit write not taken");

   chk_iso_keeps_idle: assert property (@(posedge core_clk) disable iff (!rstn)
      isolate |=> line_idle)
      else $error("line idles stopped in isolate");

   chk_iso_tx_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
      (isolate && !loopback) |=> !mii_col && mii_rx.crs == $past(line_rx.crs))
      else $error("transmit seen in isolate");

   // mode indicator checks cover bits left to the hardware by the override; chk_override_drive covers an overridden link bit
   chk_mode_one_link: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && mode_one && !ovr_en[0])
      |=> link_indicator == ($past(link_up) ^ led_polarity[0]))
      else $error("mode one link indicator wrong");

   chk_mode_one_act: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && mode_one && !ovr_en[2])
      |=> activity_collision_indicator == ($past(activity) ^ led_polarity[2]))
      else $error("mode one activity indicator wrong");

   chk_mode_two_col: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && mode_two && !ovr_en[2])
      |=> activity_collision_indicator == ($past(collision) ^ led_polarity[2]))
      else $error("mode two collision indicator wrong");

   chk_mode_three_dup: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && !mode_one && !mode_two && !ovr_en[2])
      |=> activity_collision_indicator == ($past(full_duplex) ^ led_polarity[2]))
      else $error("mode three duplex indicator wrong");

   chk_override_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      (strap_done && ovr_en[0]) |=> link_indicator == ($past(ovr_val[0]) ^ led_polarity[0]))
      else $error("override not driving indicator");

   chk_polarity_latch: assert property (@(posedge core_clk) disable iff (!rstn)
      (rstn && !strap_done) |=> led_polarity == $past(autoneg_strap))
      else $error("indicator polarity not latched");

   chk_full_crs_rx: assert property (@(posedge core_clk) disable iff (!rstn)
      (full_duplex && !loopback) |=> mii_rx.crs == $past(line_rx.crs))
      else $error("full duplex carrier sense not receive only");

   chk_packet_link: assert property (@(posedge core_clk) disable iff (!rstn)
      (!link_loss && valid_packet_10) |=> link_10)
      else $error("valid packet did not declare link");

   chk_loss_clears: assert property (@(posedge core_clk) disable iff (!rstn)
      link_loss |=> !link_10 && nlp_count == 3'h0)
      else $error("link loss did not clear link");

   chk_blink_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      (blink_count != 32'(BLINK_CYCLES - 1)) |=> $stable(blink_phase))
      else $error("blink phase moved early");

   chk_blink_toggle: assert property (@(posedge core_clk) disable iff (!rstn)
      (blink_count == 32'(BLINK_CYCLES - 1)) |=> blink_phase != $past(blink_phase))
      else $error("blink phase did not toggle");

   chk_bmc_readback: assert property (@(posedge core_clk) disable iff (!rstn)
      (mgmt_req_valid && !mgmt_req.we && mgmt_req.addr == PSL_ADDR_BASIC_MODE)
      |=> mgmt_rdata == $past(basic_mode_control))
      else $error("basic mode control read wrong");

   chk_led_readback: assert property (@(posedge core_clk) disable iff (!rstn)
      (mgmt_req_valid && !mgmt_req.we && mgmt_req.addr == PSL_ADDR_LED_OVERRIDE)
      |=> mgmt_rdata == $past(led_override_control))
      else $error("override register read wrong");

endmodule

// ### verif/psl_mac_model.sv
// behavioural mac transmit side driving the block's mii transmit inputs
`timescale 1ns/1ps
module psl_mac_model (
   input  wire logic       core_clk,
   input  wire logic       send,
   input  wire logic [3:0] nib,
   output logic            mii_tx_en = 1'b0,
   output logic [3:0]      mii_txd   = 4'h0
);
   // idle data keeps toggling so a stale nibble never passes for a loopback echo
   always @(posedge core_clk) begin
      mii_tx_en <= send;
      mii_txd   <= send ? nib : ~mii_txd;
   end
endmodule

// ### verif/tb.sv
// self-checking bench for the strap, isolate, indicator, duplex and loopback block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import psl_pkg::*;
   localparam int LIMIT = 20000;
   logic          core_clk, rstn, mreq_v, send, coll, spd, full, pdet, sdet, lp, vp, lloss;
   logic [4:0]    astrap;
   logic [2:0]    nstrap;
   logic [3:0]    nib, mtxd, ltxd;
   logic [15:0]   rdata, d;
   logic          rvalid, mtxen, oe, col, ltxen, lidle, led_l, led_s, led_a;
   psl_mgmt_req_t mreq;
   psl_rx_t       lrx, mrx;
   int            err_count, check_count, cycles, ones;

   psl_mac_model mac (.core_clk(core_clk), .send(send), .nib(nib), .mii_tx_en(mtxen),
      .mii_txd(mtxd));
   psl_top #(.BLINK_CYCLES(8)) dut (.core_clk(core_clk), .rstn(rstn),
      .mgmt_addr_strap(astrap), .autoneg_strap(nstrap), .mgmt_req_valid(mreq_v),
      .mgmt_req(mreq), .mgmt_rvalid(rvalid), .mgmt_rdata(rdata), .mii_tx_en(mtxen),
      .mii_txd(mtxd), .mii_rx(mrx), .mii_col(col), .mii_out_oe(oe), .line_rx(lrx),
      .line_collision(coll), .line_tx_en(ltxen), .line_txd(ltxd), .line_idle(lidle),
      .speed_100(spd), .resolved_full(full), .parallel_detect(pdet),
      .signal_detect(sdet), .link_pulse(lp), .valid_packet_10(vp), .link_loss(lloss),
      .link_indicator(led_l), .speed_indicator(led_s),
      .activity_collision_indicator(led_a));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // address strap is sampled on the first edge after release
   task automatic rst_to(input logic [4:0] a);
      @(posedge core_clk);
      rstn   <= 1'b0;
      astrap <= a;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic mg(input logic we, input logic [4:0] a, input logic [15:0] wd);
      @(posedge core_clk);
      mreq_v <= 1'b1;
      mreq   <= '{we: we, addr: a, wdata: wd};
      @(posedge core_clk);
      mreq_v <= 1'b0;
      #1;
      if (!we) begin
         `CHK(rvalid, 1'b1)
         d = rdata;
      end
   endtask

   task automatic t_strap();
      mg(0, PSL_ADDR_PHY_CONFIG, 0);
      `CHK(d, 16'h000b)
      `CHK(oe, 1'b1)
      mg(0, 5'h05, 0);
      `CHK(d, 16'h0000)
      mg(1, PSL_ADDR_PHY_CONFIG, 16'h0000);
      wt(2);
      `CHK(oe, 1'b1)
      rst_to(5'h00);
      wt(1);
      `CHK(oe, 1'b0)
      mg(0, PSL_ADDR_BASIC_MODE, 0);
      `CHK(d, 16'h0400)
      rst_to(5'h0b);
   endtask

   task automatic t_iso();
      mg(1, PSL_ADDR_BASIC_MODE, 16'h0400);
      @(posedge core_clk);
      send <= 1'b1;
      nib  <= 4'h5;
      spd  <= 1'b1;
      sdet <= 1'b1;
      wt(3);
      `CHK(oe, 1'b0)
      `CHK({ltxen, lidle}, 2'b01)
      mg(0, PSL_ADDR_PHY_STATUS, 0);
      `CHK(d[0], 1'b1)
      mg(1, PSL_ADDR_BASIC_MODE, 16'h0000);
      wt(2);
      `CHK({oe, ltxen, ltxd}, 6'h35)
   endtask

   task automatic t_duplex();
      @(posedge core_clk);
      spd  <= 1'b0;
      sdet <= 1'b0;
      coll <= 1'b1;
      wt(2);
      `CHK({mrx.crs, col}, 2'b11)
      @(posedge core_clk);
      full <= 1'b1;
      wt(2);
      `CHK({mrx.crs, col, ltxen}, 3'b001)
      @(posedge core_clk);
      pdet <= 1'b1;
      wt(2);
      `CHK(mrx.crs, 1'b1)
      @(posedge core_clk);
      pdet <= 1'b0;
      full <= 1'b0;
      coll <= 1'b0;
   endtask

   task automatic t_loop();
      // isolate stays clear while loopback is set
      mg(1, PSL_ADDR_BASIC_MODE, 16'h4000);
      @(posedge core_clk);
      nib <= 4'ha;
      wt(3);
      `CHK({mrx.dv, mrx.er, mrx.d, ltxen}, 7'h54)
      mg(0, PSL_ADDR_PHY_STATUS, 0);
      `CHK(d[3], 1'b1)
      mg(1, PSL_ADDR_BASIC_MODE, 16'h0000);
      @(posedge core_clk);
      send <= 1'b0;
   endtask

   task automatic pulse();
      @(posedge core_clk);
      lp <= 1'b1;
      @(posedge core_clk);
      lp <= 1'b0;
   endtask

   task automatic t_led();
      mg(1, PSL_ADDR_PHY_CONFIG, 16'h002b);
      repeat (6) pulse();
      wt(2);
      `CHK(led_l, 1'b0)
      pulse();
      wt(2);
      `CHK(led_l, 1'b1)
      @(posedge core_clk);
      spd <= 1'b1;
      wt(2);
      `CHK(led_s, 1'b0)
      @(posedge core_clk);
      spd     <= 1'b0;
      lrx.crs <= 1'b1;
      wt(2);
      `CHK({led_s, led_a}, 2'b11)
      mg(1, PSL_ADDR_PHY_CONFIG, 16'h000b);
      ones = 0;
      repeat (40) begin
         wt(1);
         ones += int'(led_l);
      end
      `CHK(ones > 0 && ones < 40, 1'b1)
      `CHK(led_a, 1'b0)
      mg(1, PSL_ADDR_PHY_CONFIG, 16'h004b);
      @(posedge core_clk);
      lrx.crs <= 1'b0;
      full    <= 1'b1;
      wt(2);
      `CHK(led_a, 1'b1)
      mg(1, PSL_ADDR_LED_OVERRIDE, 16'hffff);
      mg(0, PSL_ADDR_LED_OVERRIDE, 0);
      `CHK(d, 16'h003f)
      `CHK({led_a, led_s, led_l}, 3'b101)
      @(posedge core_clk);
      lloss <= 1'b1;
      mg(1, PSL_ADDR_LED_OVERRIDE, 16'h0000);
      wt(2);
      `CHK(led_l, 1'b0)
      @(posedge core_clk);
      lloss <= 1'b0;
      vp    <= 1'b1;
      @(posedge core_clk);
      vp <= 1'b0;
      wt(2);
      `CHK(led_l, 1'b1)
   endtask

   initial begin
      {rstn, mreq_v, send, coll, spd, full, pdet, sdet, lp, vp, lloss} = '0;
      mreq   = '0;
      lrx    = '0;
      nib    = 4'h0;
      astrap = 5'h0b;
      nstrap = 3'b010;
      rst_to(5'h0b);
      t_strap();
      t_iso();
      t_duplex();
      t_loop();
      t_led();
      wrap_up();
   end
endmodule
